// File: hdl/option_byte_config_decoder.sv
`timescale 1ns/100ps
`include "option_cfg_params.svh"

module option_byte_config_decoder
#(
	parameter int PORTS = 8,
	parameter logic [PORTS*`PADS_PER_PORT-1:0] UNBONDED_64 = 64'hFF00_0000_0000_0000
)
(
	// Clock and resets
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic porN,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Mode pins
	input wire logic progModePin,
	input wire logic testModePin,
	input wire logic icpModePin,
	// Core handshakes
	input wire logic haltWake,
	input wire logic userEraseDone,
	output logic userEraseReq,
	// Decoded settings
	output logic package80,
	output logic [PORTS*`PADS_PER_PORT-1:0] padForcePullup,
	output logic flashReadBlock,
	output logic flashWriteBlock,
	output logic cpuResetHold,
	output logic haltExitHold,
	output option_cfg_pkg::clockSource_t clockSourceSel,
	output logic [2:0] clockFreqBand,
	output logic clockDoublerEn,
	output logic detectorEn,
	output logic [1:0] detectThreshold
);
	import option_cfg_pkg::*;

	localparam int NPADS = PORTS * `PADS_PER_PORT;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] pinMetaQ;
	logic [2:0] pinSyncQ;
	logic progSync;
	logic testSync;
	logic icpSync;

	always_ff @(posedge ref_clk)
	begin
		pinMetaQ <= {icpModePin, testModePin, progModePin};
		pinSyncQ <= pinMetaQ;
	end

	assign progSync = pinSyncQ[0];
	assign testSync = pinSyncQ[1];
	assign icpSync = pinSyncQ[2];

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	logic ackQ;
	logic ackD;
	logic [31:0] datQ;
	logic [31:0] datD;
	logic busWrite;
	logic [31:0] statusWord;
	eraseState_t erStateQ;
	eraseState_t erStateD;
	logic [7:0] storeB0Q;
	logic [7:0] storeB0D;
	logic [7:0] storeB1Q;
	logic [7:0] storeB1D;
	logic protectEnQ;
	logic resetShortQ;
	logic cfgConflict;

	// Write lands on the edge where the master sees ack
	assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ackQ & wb_sel_i[0];

	assign cfgConflict = (clockDoublerEn & ((clockSourceSel != SRC_RESONATOR)
		| (clockFreqBand != `BAND_TWO_TO_FOUR))) | (protectEnQ & detectorEn);

	assign statusWord = {14'h0000, cfgConflict, erStateQ != ER_IDLE, icpSync, testSync,
		progSync, resetShortQ, protectEnQ, package80, haltExitHold, detectThreshold,
		detectorEn, clockDoublerEn, clockFreqBand, clockSourceSel};

	always_comb
	begin
		ackD = 1'b0;
		datD = datQ;
		if (!rst_n)
			datD = 32'h0000_0000;
		else if (wb_cyc_i & wb_stb_i & !ackQ)
		begin
			ackD = 1'b1;
			case (wb_adr_i)
				`OPT_ADDR_BYTE0: datD = {24'h00_0000, storeB0Q};
				`OPT_ADDR_BYTE1: datD = {24'h00_0000, storeB1Q};
				`OPT_ADDR_STATUS: datD = statusWord;
				`OPT_ADDR_CONTROL: datD = {31'h0000_0000, erStateQ != ER_IDLE};
				default: datD = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		ackQ <= ackD;
		datQ <= datD;
	end

	assign wb_ack_o = ackQ;
	assign wb_dat_o = datQ;

	// ----------------------------------------
	// Option store and erase sequence
	// ----------------------------------------
	// Store survives core reset; only power-on brings back the defaults
	logic userEraseReqQ;
	logic userEraseReqD;

	always_comb
	begin
		storeB0D = storeB0Q;
		storeB1D = storeB1Q;
		erStateD = erStateQ;
		case (erStateQ)
			ER_IDLE:
			begin
				if (busWrite & progSync & (wb_adr_i == `OPT_ADDR_BYTE0))
					storeB0D = wb_dat_i[7:0];
				if (busWrite & progSync & (wb_adr_i == `OPT_ADDR_BYTE1))
					storeB1D = wb_dat_i[7:0];
				if (busWrite & progSync & (wb_adr_i == `OPT_ADDR_CONTROL)
					& wb_dat_i[`CTL_ERASE])
					erStateD = storeB0Q[`B0_PROTECT] ? ER_OPT : ER_USER;
			end
			ER_USER:
			begin
				if (userEraseDone)
					erStateD = ER_OPT;
			end
			ER_OPT:
			begin
				storeB0D = `BYTE_ERASED;
				storeB1D = `BYTE_ERASED;
				erStateD = ER_IDLE;
			end
			default: erStateD = ER_IDLE;
		endcase
		if (!rst_n)
			erStateD = ER_IDLE;
		if (!porN)
		begin
			storeB0D = `B0_DEFAULT;
			storeB1D = `B1_DEFAULT;
			erStateD = ER_IDLE;
		end
		userEraseReqD = (erStateD == ER_USER);
	end

	always_ff @(posedge ref_clk)
	begin
		storeB0Q <= storeB0D;
		storeB1Q <= storeB1D;
		erStateQ <= erStateD;
		userEraseReqQ <= userEraseReqD;
	end

	assign userEraseReq = userEraseReqQ;

	// ----------------------------------------
	// Settings latched during reset, and the flash block taken live from the mode pins
	// ----------------------------------------
	logic pkg80Q;
	logic pkg80D;
	logic [NPADS-1:0] padQ;
	logic [NPADS-1:0] padD;
	logic protectEnD;
	logic resetShortD;
	clockSource_t srcQ;
	clockSource_t srcD;
	logic [2:0] bandQ;
	logic [2:0] bandD;
	logic doublerQ;
	logic doublerD;
	logic [1:0] detQ;
	logic [1:0] detD;
	logic blockQ;
	logic blockD;
	logic detEnQ;

	always_comb
	begin
		pkg80D = pkg80Q;
		padD = padQ;
		protectEnD = protectEnQ;
		resetShortD = resetShortQ;
		srcD = srcQ;
		bandD = bandQ;
		doublerD = doublerQ;
		detD = detQ;
		if (!rst_n)
		begin
			pkg80D = storeB1Q[`B1_PKG_HIGH] & storeB0Q[`B0_PKG_LOW];
			// Unbonded pads forced to pulled-up inputs to avoid leakage
			padD = pkg80D ? '0 : UNBONDED_64;
			protectEnD = !storeB0Q[`B0_PROTECT];
			resetShortD = storeB1Q[`B1_RSTLEN];
			srcD = clockSource_t'(storeB1Q[`B1_SRC_HI:`B1_SRC_LO]);
			bandD = storeB1Q[`B1_BAND_HI:`B1_BAND_LO];
			doublerD = !storeB1Q[`B1_DOUBLER_OFF];
			detD = storeB0Q[`B0_DET_HI:`B0_DET_LO];
		end
		blockD = protectEnD & (testSync | icpSync);
	end

	always_ff @(posedge ref_clk)
	begin
		pkg80Q <= pkg80D;
		padQ <= padD;
		protectEnQ <= protectEnD;
		resetShortQ <= resetShortD;
		srcQ <= srcD;
		bandQ <= bandD;
		doublerQ <= doublerD;
		detQ <= detD;
		detEnQ <= (detD != `DET_OFF_CODE);
		blockQ <= blockD;
	end

	assign package80 = pkg80Q;
	assign padForcePullup = padQ;
	assign flashReadBlock = blockQ;
	assign flashWriteBlock = blockQ;
	assign clockSourceSel = srcQ;
	assign clockFreqBand = bandQ;
	assign clockDoublerEn = doublerQ;
	assign detectorEn = detEnQ;
	assign detectThreshold = detQ;

	// ----------------------------------------
	// Reset and halt-exit phase timers
	// ----------------------------------------
	phase_timer u_resetTimer
	(
		.ref_clk(ref_clk),
		.clear(1'b0),
		.load(!rst_n),
		.shortSel(storeB1Q[`B1_RSTLEN]),
		.busy(cpuResetHold)
	);

	phase_timer u_haltTimer
	(
		.ref_clk(ref_clk),
		.clear(!rst_n),
		.load(haltWake),
		.shortSel(resetShortQ),
		.busy(haltExitHold)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [12:0] holdCntQ;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			holdCntQ <= 13'h0000;
		else if (cpuResetHold)
			holdCntQ <= holdCntQ + 13'h0001;
	end

	property p_pkgSelect;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> package80 == $past(storeB1Q[`B1_PKG_HIGH] & storeB0Q[`B0_PKG_LOW]);
	endproperty
	a_pkgSelect: assert property (p_pkgSelect) else $error("package decode wrong");

	property p_padPullup;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> padForcePullup == ($past(storeB1Q[`B1_PKG_HIGH]
			& storeB0Q[`B0_PKG_LOW]) ? '0 : UNBONDED_64);
	endproperty
	a_padPullup: assert property (p_padPullup) else $error("pad pull-up wrong");

	property p_flashBlock;
		@(posedge ref_clk) disable iff (!rst_n)
		(protectEnQ && (testSync || icpSync)) |=> flashReadBlock && flashWriteBlock;
	endproperty
	a_flashBlock: assert property (p_flashBlock) else $error("flash not blocked");

	property p_eraseFirst;
		@(posedge ref_clk) disable iff (!rst_n || !porN)
		(erStateQ == ER_USER && !userEraseDone) |=> userEraseReq
			&& storeB0Q == $past(storeB0Q) && storeB1Q == $past(storeB1Q);
	endproperty
	a_eraseFirst: assert property (p_eraseFirst) else $error("options erased early");

	property p_resetLength;
		@(posedge ref_clk) disable iff (!rst_n)
		$fell(cpuResetHold) |-> holdCntQ == (resetShortQ ? `RESET_CYCLES_SHORT
			: `RESET_CYCLES_LONG);
	endproperty
	a_resetLength: assert property (p_resetLength) else $error("reset phase length");

	property p_clockSource;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> clockSourceSel == $past(storeB1Q[`B1_SRC_HI:`B1_SRC_LO]);
	endproperty
	a_clockSource: assert property (p_clockSource) else $error("clock source wrong");

	property p_freqBand;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> clockFreqBand == $past(storeB1Q[`B1_BAND_HI:`B1_BAND_LO]);
	endproperty
	a_freqBand: assert property (p_freqBand) else $error("band wrong");

	property p_doubler;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> clockDoublerEn != $past(storeB1Q[`B1_DOUBLER_OFF]);
	endproperty
	a_doubler: assert property (p_doubler) else $error("doubler wrong");

	property p_detector;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> detectThreshold == $past(storeB0Q[`B0_DET_HI:`B0_DET_LO])
			&& detectorEn == (detectThreshold != 2'b11);
	endproperty
	a_detector: assert property (p_detector) else $error("detector wrong");

	property p_staticCfg;
		@(posedge ref_clk) disable iff (!rst_n)
		$past(rst_n) |-> $stable(clockSourceSel) && $stable(clockFreqBand)
			&& $stable(clockDoublerEn) && $stable(package80) && $stable(detectThreshold);
	endproperty
	a_staticCfg: assert property (p_staticCfg) else $error("settings changed");

endmodule : option_byte_config_decoder

// File: hdl/phase_timer.sv
`timescale 1ns/100ps
`include "option_cfg_params.svh"

module phase_timer
(
	// Clock
	input wire logic ref_clk,
	// Control
	input wire logic clear,
	input wire logic load,
	input wire logic shortSel,
	// Status
	output logic busy
);

	logic [12:0] cntQ;
	logic [12:0] cntD;
	logic busyQ;
	logic busyD;

	always_comb
	begin
		cntD = cntQ;
		busyD = busyQ;
		if (clear)
		begin
			cntD = 13'h0000;
			busyD = 1'b0;
		end
		else if (load)
		begin
			cntD = (shortSel ? `RESET_CYCLES_SHORT : `RESET_CYCLES_LONG) - 13'h0001;
			busyD = 1'b1;
		end
		else if (busyQ)
		begin
			if (cntQ == 13'h0000)
				busyD = 1'b0;
			else
				cntD = cntQ - 13'h0001;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		cntQ <= cntD;
		busyQ <= busyD;
	end

	assign busy = busyQ;

endmodule : phase_timer

// File: include/option_cfg_params.svh
`ifndef OPTION_CFG_PARAMS_SVH
`define OPTION_CFG_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OPT_ADDR_BYTE0 8'h00
`define OPT_ADDR_BYTE1 8'h04
`define OPT_ADDR_STATUS 8'h08
`define OPT_ADDR_CONTROL 8'h0C

// ----------------------------------------
// Configuration byte 0 fields
// ----------------------------------------
`define B0_PROTECT 0
`define B0_PKG_LOW 1
`define B0_RSVD 2
`define B0_DET_LO 3
`define B0_DET_HI 4

// ----------------------------------------
// Configuration byte 1 fields
// ----------------------------------------
`define B1_DOUBLER_OFF 0
`define B1_BAND_LO 1
`define B1_BAND_HI 3
`define B1_SRC_LO 4
`define B1_SRC_HI 5
`define B1_RSTLEN 6
`define B1_PKG_HIGH 7

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_ERASE 0

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define B0_DEFAULT 8'hE7
`define B1_DEFAULT 8'hEF
`define BYTE_ERASED 8'hFF
`define PADS_PER_PORT 8
`define RESET_CYCLES_LONG 13'd4096
`define RESET_CYCLES_SHORT 13'd256
`define DET_OFF_CODE 2'b11
`define BAND_TWO_TO_FOUR 3'b001

`endif

// File: include/option_cfg_pkg.sv
package option_cfg_pkg;

	typedef enum logic [1:0] {
		SRC_RESONATOR = 2'b00,
		SRC_RESERVED = 2'b01,
		SRC_RC = 2'b10,
		SRC_EXTERNAL = 2'b11
	} clockSource_t;

	// Gray along idle -> user erase -> option erase
	typedef enum logic [1:0] {
		ER_IDLE = 2'b00,
		ER_USER = 2'b01,
		ER_OPT = 2'b11
	} eraseState_t;

endpackage : option_cfg_pkg

// File: test/prog_tool_model.sv
`timescale 1ns/100ps
// Programming side: owns the mode pin and answers user-memory erase requests
module prog_tool_model
#(
	parameter int ERASE_DELAY = 12
)
(
	// Clock
	input wire logic ref_clk,
	// Control
	input wire logic progEn,
	input wire logic userEraseReq,
	// Device pins
	output logic progModePin,
	output logic userEraseDone
);
	int waitCnt = 0;
	assign progModePin = progEn;
	// Done comes late on purpose, so the device must really wait for it
	always @(posedge ref_clk)
	begin
		waitCnt <= userEraseReq ? waitCnt + 1 : 0;
		userEraseDone <= userEraseReq && (waitCnt >= ERASE_DELAY);
	end
	initial userEraseDone = 1'b0;
endmodule : prog_tool_model

// File: test/tb_top.sv
`timescale 1ns/100ps
`include "option_cfg_params.svh"
module tb_top;
	import option_cfg_pkg::*;
	logic ref_clk = 0, rst_n = 0, porN = 0, progEn = 1, testModePin = 0, icpModePin = 0;
	logic wbCyc = 0, wbStb = 0, wbWe = 0, haltWake = 0, wbAck, progModePin;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'hF;
	logic [31:0] wbDatI = 32'h0, wbDatO, rd;
	logic userEraseDone, userEraseReq, package80, flashReadBlock, flashWriteBlock;
	logic cpuResetHold, haltExitHold, clockDoublerEn, detectorEn;
	logic [63:0] padForcePullup;
	clockSource_t clockSourceSel;
	logic [2:0] clockFreqBand;
	logic [1:0] detectThreshold;
	int mismatches = 0, samples_checked = 0, cycles = 0, n;
	logic [1:0] srcTab [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
	always #5 ref_clk = ~ref_clk;
	option_byte_config_decoder u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .porN(porN),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.progModePin(progModePin), .testModePin(testModePin), .icpModePin(icpModePin),
		.haltWake(haltWake), .userEraseDone(userEraseDone), .userEraseReq(userEraseReq),
		.package80(package80), .padForcePullup(padForcePullup),
		.flashReadBlock(flashReadBlock), .flashWriteBlock(flashWriteBlock),
		.cpuResetHold(cpuResetHold), .haltExitHold(haltExitHold),
		.clockSourceSel(clockSourceSel), .clockFreqBand(clockFreqBand),
		.clockDoublerEn(clockDoublerEn), .detectorEn(detectorEn),
		.detectThreshold(detectThreshold));
	prog_tool_model u_tool (.ref_clk(ref_clk), .progEn(progEn), .userEraseReq(userEraseReq),
		.progModePin(progModePin), .userEraseDone(userEraseDone));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task stop_test;
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s exp %0h seen %0h", name, exp, seen);
		end
	endtask : chk
	task wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int k;
		k = 0;
		@(posedge ref_clk);
		wbCyc <= 1; wbStb <= 1; wbWe <= we; wbAdr <= adr; wbDatI <= dat;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (wbAck !== 1'b1 && k < 20);
		rd = wbDatO;
		wbCyc <= 0; wbStb <= 0; wbWe <= 0;
		if (k >= 20)
			chk("bus ack", 0, 1);
	endtask : wbCycle
	// Counts cycles that the chosen hold output stays high
	task countHold(input bit halt);
		// Called at the release or load edge itself, so that cycle counts too
		n = 0;
		#1;
		while ((halt ? haltExitHold : cpuResetHold) === 1'b1 && n < 5000)
		begin
			n++;
			@(posedge ref_clk);
			#1;
		end
	endtask : countHold
	task doReset(input logic [7:0] b0, input logic [7:0] b1);
		wbCycle(1, `OPT_ADDR_BYTE0, {24'h0, b0});
		wbCycle(1, `OPT_ADDR_BYTE1, {24'h0, b1});
		@(posedge ref_clk) rst_n <= 0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1;
		countHold(0);
	endtask : doReset
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles > 30000)
		begin
			mismatches++;
			stop_test();
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge ref_clk);
		porN <= 1;
		rst_n <= 1;
		countHold(0);
		chk("short reset", n, `RESET_CYCLES_SHORT);
		chk("default src", clockSourceSel, SRC_RC);
		chk("default pkg", package80, 1);
		testModePin <= 1;
		// Reserved bit 2 kept set, doubler off, protection off
		for (int i = 0; i < 4; i++)
		begin
			doReset({3'b111, i[1:0], 1'b1, i[0], 1'b1}, {2'b11, srcTab[i], i[2:0], 1'b1});
			chk("pkg", package80, i[0]);
			chk("pads", padForcePullup, i[0] ? 64'h0 : 64'hFF00_0000_0000_0000);
			chk("src", clockSourceSel, srcTab[i]);
			chk("band", clockFreqBand, i);
			chk("doubler", clockDoublerEn, 0);
			chk("det en", detectorEn, i != 3);
			chk("thresh", detectThreshold, i);
			chk("unprot block", flashReadBlock, 0);
		end
		testModePin <= 0;
		// Resonator with long reset, 2-4 MHz band, detector off under protection
		doReset(8'hFE, {1'b1, 1'b0, 2'b00, `BAND_TWO_TO_FOUR, 1'b0});
		chk("long reset", n, `RESET_CYCLES_LONG);
		chk("doubler on", clockDoublerEn, 1);
		chk("det off", detectorEn, 0);
		chk("no mode block", flashWriteBlock, 0);
		@(posedge ref_clk) haltWake <= 1;
		@(posedge ref_clk) haltWake <= 0;
		countHold(1);
		chk("halt hold", n, `RESET_CYCLES_LONG);
		for (int m = 0; m < 2; m++)
		begin
			@(posedge ref_clk) {icpModePin, testModePin} <= 2'b01 << m;
			repeat (5) @(posedge ref_clk);
			chk("read block", flashReadBlock, 1);
			chk("write block", flashWriteBlock, 1);
		end
		{icpModePin, testModePin} <= 2'b00;
		wbCycle(1, `OPT_ADDR_BYTE1, 32'h0000_00EF);
		repeat (3) @(posedge ref_clk);
		chk("held src", clockSourceSel, SRC_RESONATOR);
		wbCycle(1, `OPT_ADDR_CONTROL, 32'h1);
		@(posedge ref_clk) #1;
		chk("erase req", userEraseReq, 1);
		n = 0;
		while (userEraseReq === 1'b1 && n < 100)
		begin
			@(posedge ref_clk);
			n++;
		end
		chk("erase waited", n > 12, 1);
		repeat (3) @(posedge ref_clk);
		wbCycle(0, `OPT_ADDR_BYTE0, 0);
		chk("erased b0", rd, `BYTE_ERASED);
		wbCycle(0, `OPT_ADDR_BYTE1, 0);
		chk("erased b1", rd, `BYTE_ERASED);
		progEn <= 0;
		repeat (4) @(posedge ref_clk);
		wbCycle(1, `OPT_ADDR_BYTE0, 32'h0);
		wbCycle(0, `OPT_ADDR_BYTE0, 0);
		chk("locked b0", rd, `BYTE_ERASED);
		wbCycle(0, 8'h20, 0);
		chk("unmapped", rd, 0);
		stop_test();
	end
endmodule : tb_top
